/* hdl/odcr_consts.svh */
`ifndef ODCR_CONSTS_SVH
`define ODCR_CONSTS_SVH

`define ODCR_ADDR_WIDTH 10
`define ODCR_SOURCE_OFFSET 10'h241
`define ODCR_FIRST_OFFSET 10'h242
`define ODCR_SECOND_OFFSET 10'h243

`define ODCR_SWING_BIT 7
`define ODCR_FORMAT_HI 6
`define ODCR_FORMAT_LO 4
`define ODCR_POLARITY_HI 3
`define ODCR_POLARITY_LO 2
`define ODCR_STRENGTH_BIT 1
`define ODCR_ON_BIT 0
`define ODCR_SOURCE_BIT 7

`define ODCR_DRIVER_RESET 8'hc1
`define ODCR_SOURCE_RESET 1'h0

`endif

/* hdl/odcr_pkg.sv */
package odcr_pkg;

	typedef enum logic [2:0] {
		ODCR_FMT_TRISTATE = 3'h0,
		ODCR_FMT_HSTL = 3'h1,
		ODCR_FMT_LVDS = 3'h2,
		ODCR_FMT_HCSL = 3'h3,
		ODCR_FMT_CMOS_BOTH = 3'h4,
		ODCR_FMT_CMOS_POS = 3'h5,
		ODCR_FMT_CMOS_NEG = 3'h6,
		ODCR_FMT_RESERVED = 3'h7
	} odcr_format_type;

	typedef enum logic [1:0] {
		ODCR_POL_TRUE_INV = 2'h0,
		ODCR_POL_INV_INV = 2'h1,
		ODCR_POL_TRUE_TRUE = 2'h2,
		ODCR_POL_INV_TRUE = 2'h3
	} odcr_polarity_type;

	typedef struct packed {
		logic fullSwing;
		odcr_format_type format;
		odcr_polarity_type polarity;
		logic lowDrive;
		logic on;
	} odcr_driver_type;

	typedef struct packed {
		logic active;
		logic isCmos;
		logic isLvds;
		logic strengthApplies;
		logic fullSwingCmos;
		logic reservedFormat;
	} odcr_status_type;

endpackage

/* hdl/odcr_driver_decode.sv */
`timescale 1ns/1ps
`include "odcr_consts.svh"

module odcr_driver_decode
	import odcr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	input wire logic [7:0] regValue,
	output odcr_driver_type driver,
	output odcr_status_type status
);

	odcr_driver_type next_driver;
	odcr_status_type next_status;

	always_comb begin
		next_driver.fullSwing = regValue[`ODCR_SWING_BIT];
		next_driver.format = odcr_format_type'(regValue[`ODCR_FORMAT_HI:`ODCR_FORMAT_LO]);
		next_driver.polarity = odcr_polarity_type'(regValue[`ODCR_POLARITY_HI:`ODCR_POLARITY_LO]);
		next_driver.lowDrive = regValue[`ODCR_STRENGTH_BIT];
		next_driver.on = regValue[`ODCR_ON_BIT];
		next_status.isCmos = 1'b0;
		next_status.isLvds = 1'b0;
		next_status.reservedFormat = 1'b0;
		case (next_driver.format)
			ODCR_FMT_CMOS_BOTH, ODCR_FMT_CMOS_POS, ODCR_FMT_CMOS_NEG: begin
				next_status.isCmos = 1'b1;
			end
			ODCR_FMT_LVDS: begin
				next_status.isLvds = 1'b1;
			end
			ODCR_FMT_RESERVED: begin
				next_status.reservedFormat = 1'b1;
			end
			default: begin
				next_status.isCmos = 1'b0;
			end
		endcase
		// swing and polarity matter only for cmos
		next_status.fullSwingCmos = next_status.isCmos & next_driver.fullSwing;
		next_status.strengthApplies = next_status.isLvds | next_status.fullSwingCmos;
		// powered down or tristate means no drive
		next_status.active = next_driver.on & (next_driver.format != ODCR_FMT_TRISTATE)
			& ~next_status.reservedFormat;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			driver <= odcr_driver_type'(`ODCR_DRIVER_RESET);
			status <= '0;
		end else if (clockEnable) begin
			driver <= next_driver;
			status <= next_status;
		end
	end

endmodule

/* hdl/output_driver_config_regs.sv */
`timescale 1ns/1ps
`include "odcr_consts.svh"

// How it works
// - first output bit7 selects CMOS swing
// - second output bit7 selects CMOS swing
// - first output bits6-4 select driver format
// - second output bits6-4 select driver format
// - bits3-2 set CMOS leg polarities
// - first output bit1 selects drive strength
// - second output bit1 selects drive strength
// - bit0 enables each output driver
// - source bit picks divider or reference
module output_driver_config_regs
	import odcr_pkg::*;
#(
	parameter int ADDR_WIDTH = `ODCR_ADDR_WIDTH
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic [7:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [7:0] readData,
	input wire logic dividerClockIn,
	input wire logic referenceClockIn,
	output logic outputPairClock,
	output logic outputPairSource,
	output odcr_driver_type firstDriver,
	output odcr_driver_type secondDriver,
	output odcr_status_type firstStatus,
	output odcr_status_type secondStatus
);

	logic [7:0] configReg [2];
	odcr_driver_type [1:0] driverOut;
	odcr_status_type [1:0] statusOut;
	logic sourceSelect;
	logic [7:0] next_readData;

	localparam logic [ADDR_WIDTH-1:0] OFFSETS [2] = '{
		ADDR_WIDTH'(`ODCR_FIRST_OFFSET), ADDR_WIDTH'(`ODCR_SECOND_OFFSET)};

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : gen_channel
			// field meaning per channel lives in the decoder
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					configReg[i] <= `ODCR_DRIVER_RESET;
				end else if (clockEnable && writeStrobe && address == OFFSETS[i]) begin
					configReg[i] <= writeData;
				end
			end

			odcr_driver_decode u_decode (
				.clock(clock),
				.rst_n(rst_n),
				.clockEnable(clockEnable),
				.regValue(configReg[i]),
				.driver(driverOut[i]),
				.status(statusOut[i])
			);
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sourceSelect <= `ODCR_SOURCE_RESET;
		end else if (clockEnable && writeStrobe
			&& address == ADDR_WIDTH'(`ODCR_SOURCE_OFFSET)) begin
			sourceSelect <= writeData[`ODCR_SOURCE_BIT];
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		next_readData = 8'h00;
		if (address == OFFSETS[0]) begin
			next_readData = configReg[0];
		end else if (address == OFFSETS[1]) begin
			next_readData = configReg[1];
		end else if (address == ADDR_WIDTH'(`ODCR_SOURCE_OFFSET)) begin
			next_readData[`ODCR_SOURCE_BIT] = sourceSelect;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readData <= 8'h00;
		end else if (clockEnable) begin
			readData <= readStrobe ? next_readData : 8'h00;
		end
	end

	assign outputPairSource = sourceSelect;
	// glitch-free switching is left to the analog mux
	assign outputPairClock = sourceSelect ? referenceClockIn : dividerClockIn;

	assign firstDriver = driverOut[0];
	assign secondDriver = driverOut[1];
	assign firstStatus = statusOut[0];
	assign secondStatus = statusOut[1];

endmodule

/* testbench/odcr_assertions.sv */
`timescale 1ns/1ps
module odcr_assertions
	import odcr_pkg::*;
(
	input logic clock,
	input logic rst_n,
	input logic clockEnable,
	input logic [9:0] address,
	input logic [7:0] writeData,
	input logic writeStrobe,
	input logic readStrobe,
	input logic [7:0] readData,
	input logic outputPairSource,
	input odcr_driver_type firstDriver,
	input odcr_driver_type secondDriver
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	wire ce = clockEnable;
	wire wa = writeStrobe && ce && address == 10'h242;
	wire wb = writeStrobe && ce && address == 10'h243;
	wire ws = writeStrobe && ce && address == 10'h241;
	a_swing_two: assert property (wb ##1 ce |=>
		secondDriver[7] == $past(writeData[7], 2)) else $error("swing two");
	a_source_write: assert property (ws |=>
		outputPairSource == $past(writeData[7])) else $error("source select");
	a_swing_one: assert property (wa ##1 ce |=>
		firstDriver[7] == $past(writeData[7], 2)) else $error("swing");
	a_format_one: assert property (wa ##1 ce |=>
		firstDriver[6:4] == $past(writeData[6:4], 2)) else $error("format");
	a_format_two: assert property (wb ##1 ce |=>
		secondDriver[6:4] == $past(writeData[6:4], 2)) else $error("format");
	a_leg_polarity: assert property (wb ##1 ce |=>
		secondDriver[3:2] == $past(writeData[3:2], 2)) else $error("polarity");
	a_strength_one: assert property (wa ##1 ce |=>
		firstDriver[1] == $past(writeData[1], 2)) else $error("strength");
	a_strength_two: assert property (wb ##1 ce |=>
		secondDriver[1] == $past(writeData[1], 2)) else $error("strength");
	a_driver_on: assert property (wa ##1 ce |=>
		firstDriver[0] == $past(writeData[0], 2)) else $error("enable");
	a_read_idle: assert property (!readStrobe && ce |=>
		readData == 8'h00) else $error("read idle");
endmodule

/* testbench/output_driver_config_regs_test.sv */
`timescale 1ns/1ps
module output_driver_config_regs_test;
	logic clock = 0;
	logic rst_n = 0;
	logic ce = 1;
	logic [9:0] addr = 0;
	logic [7:0] wd = 0;
	logic ws = 0;
	logic rs = 0;
	logic divClk = 0;
	logic refClk = 0;
	logic [7:0] rdata;
	logic outClk;
	logic srcOut;
	logic [5:0] stat1;
	logic [5:0] stat2;
	logic [7:0] d1;
	logic [7:0] d2;
	logic [7:0] m[3];
	logic [31:0] s = 32'h633b;
	logic [31:0] r;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #10 clock = ~clock;
	output_driver_config_regs dut(.clock(clock), .rst_n(rst_n), .clockEnable(ce), .address(addr),
		.writeData(wd), .writeStrobe(ws), .readStrobe(rs), .readData(rdata),
		.dividerClockIn(divClk), .referenceClockIn(refClk), .outputPairClock(outClk),
		.outputPairSource(srcOut), .firstDriver(d1), .secondDriver(d2), .firstStatus(stat1),
		.secondStatus(stat2));
	function automatic logic [7:0] stx(input logic [7:0] v);
		logic c;
		logic l;
		logic x;
		c = v[6:4] >= 3'h4 && v[6:4] <= 3'h6;
		l = v[6:4] == 3'h2;
		x = v[6:4] == 3'h7;
		return {2'h0, v[0] && v[6:4] != 3'h0 && !x, c, l, l || (c && v[7]), c && v[7], x};
	endfunction
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task close_out;
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wr(input logic [9:0] a, input logic [7:0] d);
		addr <= a;
		wd <= d;
		ws <= 1'h1;
		@(posedge clock);
		ws <= 1'h0;
		if (ce && a >= 10'h241 && a <= 10'h243)
			m[a - 10'h241] = (a == 10'h241) ? (d & 8'h80) : d;
	endtask
	task rd(input logic [9:0] a);
		addr <= a;
		rs <= 1'h1;
		@(posedge clock);
		rs <= 1'h0;
		@(negedge clock);
		cmp("readData", (a >= 10'h241 && a <= 10'h243) ? m[a - 10'h241] : 8'h00, rdata);
		cmp("firstDriver", m[1], d1);
		cmp("secondDriver", m[2], d2);
		cmp("outClk", {7'h0, m[0][7] ? refClk : divClk}, {7'h0, outClk});
		cmp("outputPairSource", {7'h0, m[0][7]}, {7'h0, srcOut});
		cmp("firstStatus", stx(m[1]), {2'h0, stat1});
		cmp("secondStatus", stx(m[2]), {2'h0, stat2});
		@(posedge clock);
	endtask
	initial begin
		m[0] = 8'h00;
		m[1] = 8'hc1;
		m[2] = 8'hc1;
		repeat (8) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		rd(10'h242);
		rd(10'h243);
		rd(10'h241);
		for (int i = 0; i < 300; i++) begin
			r = xs();
			divClk <= r[24];
			refClk <= r[25];
			wr(10'h241 + {8'h00, r[9:8]}, r[7:0]);
			rd(10'h241 + {8'h00, r[17:16]});
		end
		ce <= 1'h0;
		wr(10'h243, 8'h00);
		ce <= 1'h1;
		rd(10'h243);
		close_out();
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc > 9000) begin
			errors++;
			close_out();
		end
	end
endmodule
bind output_driver_config_regs odcr_assertions chk(.clock(clock), .rst_n(rst_n),
	.clockEnable(clockEnable), .address(address), .writeData(writeData),
	.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
	.outputPairSource(outputPairSource), .firstDriver(firstDriver),
	.secondDriver(secondDriver));
